// ===== lagc_map.svh
// register offsets, field positions, reset values and timing bases
`ifndef LAGC_MAP_SVH
`define LAGC_MAP_SVH
`define LAGC_OFS_CTRL1      8'h56
`define LAGC_OFS_CTRL2      8'h57
`define LAGC_OFS_MAXG       8'h58
`define LAGC_OFS_ATK        8'h59
`define LAGC_OFS_DEC        8'h5A
`define LAGC_OFS_NDB        8'h5B
`define LAGC_OFS_GAIN       8'h5D
`define LAGC_RST_CTRL1      8'h00
`define LAGC_RST_CTRL2      8'h00
`define LAGC_RST_MAXG       7'h7F
`define LAGC_RST_TIME       8'h00
`define LAGC_RST_NDB        5'h00
`define LAGC_EN_BIT         7
`define LAGC_MAXG_LIMIT     7'h50
`define LAGC_ATK_SHIFT      5
`define LAGC_DEC_SHIFT      9
`define LAGC_DBN_SHIFT      12
`define LAGC_NTHR_BASE      9'h038
`define LAGC_HYST_OFF       2'h3
`endif

// ===== lagc_pkg.sv
// types shared by the left gain control modules
package lagc_pkg;
  typedef enum logic [1:0] {LAGC_HOLD, LAGC_ATTACK, LAGC_DECAY} lagc_dir_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  tgt;
    logic [1:0]  hyst;
    logic [4:0]  nthr;
    logic        clip_en;
    logic [6:0]  maxg;
    logic [7:0]  atk;
    logic [7:0]  dec;
    logic [4:0]  ndb;
    logic [6:0]  gain;
    logic [23:0] ncnt;
    logic        noise;
    lagc_dir_t   dir;
    logic [7:0]  rdata;
  } lagc_state_t;

  typedef struct packed {
    logic [23:0] cnt;
    logic        expire;
  } lagc_tmr_state_t;
endpackage

// ===== lagc_tmr_if.sv
// carrier between the gain control and its sample period timer
`timescale 1ns/100ps
`default_nettype none
interface lagc_tmr_if;
  logic        tick;
  logic        restart;
  logic [23:0] period;
  logic        expire;
  modport ctrl (output tick, output restart, output period, input expire);
  modport tmr  (input tick, input restart, input period, output expire);
endinterface
`default_nettype wire

// ===== lagc_period_timer.sv
// sample-counting timer that pulses once per programmed period
`timescale 1ns/100ps
`default_nettype none
`include "lagc_map.svh"
module lagc_period_timer
  import lagc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  lagc_tmr_if.tmr   t
);
  lagc_tmr_state_t s_q;
  lagc_tmr_state_t s_d;

  // advance only on a sample tick so time scales with fS
  always_comb begin
    s_d        = s_q;
    s_d.expire = 1'b0;
    if (t.restart) begin
      s_d.cnt = 24'h000000;
    end else if (t.tick) begin
      if (s_q.cnt + 24'h000001 >= t.period) begin // R14
        s_d.cnt    = 24'h000000;
        s_d.expire = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.expire = s_q.expire;

  property p_expire_on_tick;
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_q.expire |-> $past(t.tick) && !$past(t.restart);
  endproperty
  a_expire_on_tick: assert property (p_expire_on_tick) // R14
    else $error("timer expired without a sample tick");

  property p_expire_at_period;
    @(posedge mclk_i) disable iff (!reset_n_i)
    $rose(s_q.expire) |-> $past(s_q.cnt) + 24'h000001 >= $past(t.period);
  endproperty
  a_expire_at_period: assert property (p_expire_at_period) // R8
    else $error("timer expired before its period");
endmodule
`default_nettype wire

// ===== lagc_ctrl.sv
// left channel automatic gain control with its parameter registers
// Operation
// R1: gain control runs only while enable bit 7 of first register is set.
// R2: three-bit target picks -5.5 to -24 dB output level.
// R3: two-bit hysteresis gives 1, 2, 4 dB dead band or none.
// R4: noise threshold code 0 disables detection; else -30 dB minus 2 dB steps.
// R5: bit 0 of second register enables clip stepping.
// R6: seven-bit ceiling limits gain in 0.5 dB steps, resets all ones.
// R7: software must not write ceiling codes above 40 dB.
// R8: attack base time is (2N+1) times 32 sample periods.
// R9: attack multiplier scales attack time by two to the M.
// R10: decay base time is (2N+1) times 512 sample periods.
// R11: decay multiplier scales decay time by two to the M.
// R12: noise must persist for the debounce time before control reacts.
// R13: reserved bits take reset value on write and read as zero.
// R14: all timing counts audio samples, so it scales with sample rate.
`timescale 1ns/100ps
`default_nettype none
`include "lagc_map.svh"
module lagc_ctrl
  import lagc_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       reset_n_i,
  input  wire logic       sample_tick_i,
  input  wire logic [7:0] level_i,
  input  wire logic       clip_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [6:0] gain_o,
  output logic            noise_o
);
  lagc_state_t s_q;
  lagc_state_t s_d;
  lagc_tmr_if  tmr ();

  // target level as attenuation in half dB
  function automatic logic [8:0] tgt_att(input logic [2:0] c);
    case (c)
      3'h0:    tgt_att = 9'h00B;
      3'h1:    tgt_att = 9'h010;
      3'h2:    tgt_att = 9'h014;
      3'h3:    tgt_att = 9'h018;
      3'h4:    tgt_att = 9'h01C;
      3'h5:    tgt_att = 9'h022;
      3'h6:    tgt_att = 9'h028;
      default: tgt_att = 9'h030;
    endcase
  endfunction

  // dead band in half dB, none for code 3
  function automatic logic [8:0] hyst_hd(input logic [1:0] c);
    case (c)
      2'h0:    hyst_hd = 9'h002;
      2'h1:    hyst_hd = 9'h004;
      2'h2:    hyst_hd = 9'h008;
      default: hyst_hd = 9'h000;
    endcase
  endfunction

  // debounce length in samples
  function automatic logic [23:0] dbn_len(input logic [4:0] c);
    if (c == 5'h00) begin
      dbn_len = 24'h000000;
    end else if (c <= 5'h0B) begin
      dbn_len = 24'h000004 << (c - 5'h01);
    end else begin
      dbn_len = (24'(c) - 24'h00000A) << `LAGC_DBN_SHIFT;
    end
  endfunction

  logic [8:0]  out_att;
  logic [8:0]  lo_bound;
  logic [8:0]  hi_bound;
  logic        loud;
  logic        quiet;
  logic        below_thr;
  lagc_dir_t   want;

  // level comparisons against target window and noise floor
  always_comb begin
    out_att  = {1'b0, level_i} - {2'h0, s_q.gain};
    lo_bound = tgt_att(s_q.tgt) - hyst_hd(s_q.hyst); // R2 R3
    hi_bound = tgt_att(s_q.tgt) + hyst_hd(s_q.hyst); // R3
    loud     = level_i < {2'h0, s_q.gain} || out_att < lo_bound;
    quiet    = !loud && out_att > hi_bound;
    below_thr = s_q.nthr != 5'h00 &&
                {1'b0, level_i} >
                `LAGC_NTHR_BASE + {2'h0, s_q.nthr, 2'h0}; // R4
    if (!s_q.en) begin
      want = LAGC_HOLD;
    end else if (loud && s_q.gain != 7'h00) begin
      want = LAGC_ATTACK;
    end else if (quiet && !s_q.noise && s_q.gain < s_q.maxg) begin
      want = LAGC_DECAY;
    end else begin
      want = LAGC_HOLD;
    end
  end

  // step period from the direction being timed
  assign tmr.tick    = sample_tick_i; // R14
  assign tmr.restart = want != s_q.dir || want == LAGC_HOLD;
  assign tmr.period  = (want == LAGC_ATTACK)
    ? 24'({s_q.atk[7:3], 1'b1}) << (`LAGC_ATK_SHIFT + s_q.atk[2:0]) // R8 R9
    : 24'({s_q.dec[7:3], 1'b1}) << (`LAGC_DEC_SHIFT + s_q.dec[2:0]); // R10 R11

  lagc_period_timer lagc_period_timer_i (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .t         (tmr)
  );

  // next state: register writes, gain stepping, noise debounce, reads
  always_comb begin
    s_d     = s_q;
    s_d.dir = want;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LAGC_OFS_CTRL1: begin
          s_d.en  = reg_wdata_i[`LAGC_EN_BIT]; // R1
          s_d.tgt = reg_wdata_i[6:4];
        end
        `LAGC_OFS_CTRL2: begin
          s_d.hyst    = reg_wdata_i[7:6];
          s_d.nthr    = reg_wdata_i[5:1];
          s_d.clip_en = reg_wdata_i[0]; // R5
        end
        `LAGC_OFS_MAXG: s_d.maxg = reg_wdata_i[6:0]; // R6
        `LAGC_OFS_ATK:  s_d.atk  = reg_wdata_i;
        `LAGC_OFS_DEC:  s_d.dec  = reg_wdata_i;
        `LAGC_OFS_NDB:  s_d.ndb  = reg_wdata_i[4:0];
        default: ;
      endcase
    end
    // noise must hold for the debounce length before gain stops rising
    if (!below_thr) begin
      s_d.ncnt  = 24'h000000;
      s_d.noise = 1'b0;
    end else if (s_q.ncnt >= dbn_len(s_q.ndb)) begin
      s_d.noise = 1'b1; // R12
    end else if (sample_tick_i) begin
      s_d.ncnt = s_q.ncnt + 24'h000001;
    end
    // clip stepping wins over timed steps so peaks fall fast
    if (!s_q.en) begin
      s_d.gain = 7'h00; // R1
    end else if (sample_tick_i && clip_i && s_q.clip_en &&
                 s_q.gain != 7'h00) begin
      s_d.gain = s_q.gain - 7'h01; // R5
    end else if (tmr.expire && s_q.dir == LAGC_ATTACK &&
                 s_q.gain != 7'h00) begin
      s_d.gain = s_q.gain - 7'h01; // R8
    end else if (tmr.expire && s_q.dir == LAGC_DECAY &&
                 s_q.gain < s_q.maxg) begin
      s_d.gain = s_q.gain + 7'h01; // R10
    end
    // a lowered ceiling pulls the gain down at once
    if (s_q.gain > s_q.maxg) begin
      s_d.gain = s_q.maxg; // R6
    end
    // reserved bits read as zero
    s_d.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LAGC_OFS_CTRL1: s_d.rdata = {s_q.en, s_q.tgt, 4'h0}; // R13
        `LAGC_OFS_CTRL2: s_d.rdata = {s_q.hyst, s_q.nthr, s_q.clip_en};
        `LAGC_OFS_MAXG:  s_d.rdata = {1'b0, s_q.maxg}; // R13
        `LAGC_OFS_ATK:   s_d.rdata = s_q.atk;
        `LAGC_OFS_DEC:   s_d.rdata = s_q.dec;
        `LAGC_OFS_NDB:   s_d.rdata = {3'h0, s_q.ndb}; // R13
        `LAGC_OFS_GAIN:  s_d.rdata = {1'b0, s_q.gain};
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s_q      <= '0;
      s_q.maxg <= `LAGC_RST_MAXG; // R6
      s_q.dir  <= LAGC_HOLD;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign gain_o      = s_q.gain;
  assign noise_o     = s_q.noise;

  property p_off_zero_gain;
    @(posedge mclk_i) disable iff (!reset_n_i)
    !s_q.en |=> s_q.gain == 7'h00;
  endproperty
  a_off_zero_gain: assert property (p_off_zero_gain) // R1
    else $error("gain not zero while control disabled");

  property p_gain_ceiling;
    @(posedge mclk_i) disable iff (!reset_n_i)
    $stable(s_q.maxg) |-> s_q.gain <= s_q.maxg;
  endproperty
  a_gain_ceiling: assert property (p_gain_ceiling) // R6
    else $error("gain above ceiling");

  property p_maxg_reset;
    @(posedge mclk_i)
    $rose(reset_n_i) |-> s_q.maxg == `LAGC_RST_MAXG;
  endproperty
  a_maxg_reset: assert property (p_maxg_reset) // R6
    else $error("ceiling reset value wrong");

  property p_clip_step;
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_q.en && sample_tick_i && clip_i && s_q.clip_en &&
      s_q.gain != 7'h00 && s_q.gain <= s_q.maxg
      |=> s_q.gain == $past(s_q.gain) - 7'h01;
  endproperty
  a_clip_step: assert property (p_clip_step) // R5
    else $error("clip step missing");

  property p_noise_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
    s_q.nthr == 5'h00 |=> !s_q.noise;
  endproperty
  a_noise_off: assert property (p_noise_off) // R4
    else $error("noise flagged with detection off");

  property p_noise_debounce;
    @(posedge mclk_i) disable iff (!reset_n_i)
    $rose(s_q.noise) |-> $past(s_q.ncnt) >= dbn_len($past(s_q.ndb));
  endproperty
  a_noise_debounce: assert property (p_noise_debounce) // R12
    else $error("noise flagged before debounce");

  property p_rsvd_zero;
    @(posedge mclk_i) disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `LAGC_OFS_CTRL1 |=> reg_rdata_o[3:0] == 4'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R13
    else $error("reserved bits read nonzero");

  c_attack: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_q.dir == LAGC_ATTACK && tmr.expire);
  c_decay: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_q.dir == LAGC_DECAY && tmr.expire);
  c_noise: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(s_q.noise));
endmodule
`default_nettype wire

// ===== lagc_ctrl_bench.sv
// self-checking bench for the left channel gain control
`timescale 1ns/100ps
`default_nettype none
`include "lagc_map.svh"
module lagc_ctrl_bench;
  logic        mclk_i    = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        tick      = 1'b0;
  logic [7:0]  level     = 8'h00;
  logic        clip      = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic        wr        = 1'b0;
  logic [7:0]  wdata     = 8'h00;
  logic        rd        = 1'b0;
  logic [7:0]  rdata;
  logic [6:0]  gain;
  logic        noise;
  logic [31:0] seed      = 32'h9F6A;
  logic [7:0]  shadow [6];
  int          err_total = 0;
  int          num_checks = 0;

  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;

  lagc_ctrl lagc_ctrl_i (
    .mclk_i        (mclk_i),
    .reset_n_i     (reset_n_i),
    .sample_tick_i (tick),
    .level_i       (level),
    .clip_i        (clip),
    .reg_addr_i    (addr),
    .reg_wr_i      (wr),
    .reg_wdata_i   (wdata),
    .reg_rd_i      (rd),
    .reg_rdata_o   (rdata),
    .gain_o        (gain),
    .noise_o       (noise)
  );

  // xorshift step, seeded so every run sees the same traffic
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // writable bits per register; reserved ones must read zero
  function automatic logic [7:0] rmask(input int i);
    if (i == 0)
      return 8'hF0;
    if (i == 2)
      return 8'h7F;
    if (i == 5)
      return 8'h1F;
    return 8'hFF;
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // one audio sample every two clocks keeps long counts short
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      tick <= 1'b1;
      @(posedge mclk_i);
      tick <= 1'b0;
    end
  endtask

  // gain seen both at the pin and through the status register
  task automatic gchk(input logic [6:0] g);
    logic [7:0] d;
    repeat (2) @(posedge mclk_i);
    #1 chk("gain_o", {1'b0, gain}, {1'b0, g});
    rd_reg(`LAGC_OFS_GAIN, d);
    chk("gain status", d, {1'b0, g});
  endtask

  task automatic nchk(input logic n);
    repeat (2) @(posedge mclk_i);
    #1 chk("noise_o", {7'h00, noise}, {7'h00, n});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // cut a hang well past the expected run of some 8000 cycles
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  initial begin
    logic [7:0] d;
    int         i;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 6; i++) begin
      shadow[i] = (i == 2) ? 8'h7F : 8'h00;
      rd_reg(8'h56 + i[7:0], d);
      chk("reset value", d, shadow[i]);
    end
    rd_reg(8'h60, d);
    chk("unmapped read", d, 8'h00);
    $display("test reset values done");
    // random writes, reserved bits kept at reset value
    repeat (40) begin
      seed = xs(seed);
      i = int'(seed[15:8]) % 6;
      d = seed[7:0] & rmask(i);
      if (i == 2 && d > 8'h50)
        d = d % 8'h51;
      level <= seed[31:24];
      wr_reg(8'h56 + i[7:0], d);
      shadow[i] = d;
      wr_reg(8'h61, seed[23:16]);
      i = int'(seed[26:24]) % 6;
      rd_reg(8'h56 + i[7:0], d);
      chk("register", d, shadow[i]);
    end
    $display("test register access done");
    // known setup: disabled, target code 0, fastest timing
    for (i = 0; i < 6; i++)
      wr_reg(8'h56 + i[7:0], (i == 2) ? `LAGC_MAXG_LIMIT : 8'h00);
    level <= 8'd40;
    wr_reg(`LAGC_OFS_CTRL1, 8'h80);
    ticks(500);
    gchk(7'h00);
    ticks(30);
    gchk(7'h01);
    wr_reg(`LAGC_OFS_CTRL1, 8'h00);
    gchk(7'h00);
    wr_reg(`LAGC_OFS_CTRL1, 8'h80);
    ticks(530);
    gchk(7'h01);
    level <= 8'd5;
    ticks(40);
    gchk(7'h00);
    $display("test timed steps done");
    level <= 8'd40;
    ticks(530);
    gchk(7'h01);
    wr_reg(`LAGC_OFS_MAXG, 8'h00);
    ticks(530);
    gchk(7'h00);
    wr_reg(`LAGC_OFS_MAXG, `LAGC_MAXG_LIMIT);
    ticks(530);
    gchk(7'h01);
    wr_reg(`LAGC_OFS_CTRL2, 8'h01);
    clip <= 1'b1;
    ticks(1);
    clip <= 1'b0;
    gchk(7'h00);
    $display("test ceiling and clip done");
    // noise detection off, then threshold -30 dB
    wr_reg(`LAGC_OFS_CTRL2, 8'h00);
    level <= 8'd100;
    ticks(8);
    nchk(1'b0);
    wr_reg(`LAGC_OFS_CTRL2, 8'h02);
    ticks(8);
    nchk(1'b1);
    level <= 8'd40;
    ticks(8);
    nchk(1'b0);
    wr_reg(`LAGC_OFS_NDB, 8'h01);
    level <= 8'd100;
    ticks(2);
    nchk(1'b0);
    ticks(6);
    nchk(1'b1);
    $display("test noise done");
    // target code 7 with no dead band, attack time doubled
    wr_reg(`LAGC_OFS_CTRL1, 8'h00);
    wr_reg(`LAGC_OFS_CTRL2, 8'hC0);
    wr_reg(`LAGC_OFS_ATK, 8'h01);
    level <= 8'd49;
    wr_reg(`LAGC_OFS_CTRL1, 8'hF0);
    ticks(520);
    gchk(7'h01);
    // output now sits exactly on target, so the gain must hold
    ticks(520);
    gchk(7'h01);
    level <= 8'd47;
    ticks(40);
    gchk(7'h01);
    ticks(30);
    gchk(7'h00);
    $display("test target and multiplier done");
    stop_test();
  end
endmodule
`default_nettype wire
